// ---- hdl/byte_counter.v ----
`timescale 1ns/1ps

// Counts bytes or blocks up from zero to a loaded limit
module byte_counter (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	// Control
	input  wire        load,
	input  wire [31:0] limit,
	input  wire        step,
	// State
	output wire        done,
	output wire [31:0] sent
);
	reg [31:0] limitFf;
	reg [31:0] sentFf;

	// Load clears the count; step advances until the limit
	always @(posedge core_clk) begin
		if (!rst_b) begin
			limitFf <= 32'h0;
			sentFf  <= 32'h0;
		end else if (load) begin
			limitFf <= limit;
			sentFf  <= 32'h0;
		end else if (step && !done) begin
			sentFf  <= sentFf + 32'h1;
		end
	end
	assign done = (sentFf == limitFf);
	assign sent = sentFf;
endmodule

// ---- hdl/cdb_decoder_consts.vh ----
`ifndef CDB_DECODER_CONSTS_VH
`define CDB_DECODER_CONSTS_VH

// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define REG_CTRL        4'h0
`define REG_CDB0        4'h1
`define REG_CDB1        4'h2
`define REG_CDB2        4'h3
`define REG_STATUS      4'h4
`define REG_LBA         4'h5
`define REG_XFER        4'h6
`define REG_AVAIL       4'h7
`define REG_RESULT      4'h8
`define REG_SENT        4'h9

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_GO_BIT     0
`define CTRL_IDENT_BIT  1
`define CTRL_LINKOK_BIT 2
`define CTRL_FAIL_BIT   3
`define CTRL_LENKIND_LO 4
`define CTRL_LENKIND_HI 5
`define CTRL_STEP_BIT   6
`define CTRL_RESET      8'h00

// ----------------------------------------
// Length field kinds
// ----------------------------------------
`define LEN_TRANSFER    2'h0
`define LEN_PARAM       2'h1
`define LEN_ALLOC       2'h2

// ----------------------------------------
// Group codes and block lengths
// ----------------------------------------
`define GROUP_SIX       3'h0
`define GROUP_TEN_A     3'h1
`define GROUP_TEN_B     3'h2
`define GROUP_TWELVE    3'h5
`define LEN_SIX         4'h6
`define LEN_TEN         4'ha
`define LEN_TWELVE      4'hc

// ----------------------------------------
// Outcome codes
// ----------------------------------------
`define OUT_NONE        3'h0
`define OUT_COMPLETE    3'h1
`define OUT_LINKED      3'h2
`define OUT_LINKED_FLAG 3'h3
`define OUT_CHECK       3'h4

`endif

// ---- hdl/cdb_field_decoder.v ----
`timescale 1ns/1ps
`include "cdb_decoder_consts.vh"

module cdb_field_decoder (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// Medium and phase outputs
	output reg         mediumWriteEn,
	output reg         cmdPhase,
	output reg         dataInActive
);
	// ----------------------------------------
	// State machine codes
	// ----------------------------------------
	localparam [4:0] ST_IDLE   = 5'b00001;
	localparam [4:0] ST_DECODE = 5'b00010;
	localparam [4:0] ST_XFER   = 5'b00100;
	localparam [4:0] ST_STATUS = 5'b01000;
	localparam [4:0] ST_MSG    = 5'b10000;

	// Status and sense codes reported in the result register
	localparam [3:0] STS_GOOD  = 4'h0;
	localparam [3:0] STS_CHECK = 4'h1;
	localparam [3:0] STS_INTER = 4'h4;
	localparam [3:0] SENSE_ILLEGAL = 4'h5;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0]  ctrlFf;
	reg [31:0] cdb0Ff;
	reg [31:0] cdb1Ff;
	reg [31:0] cdb2Ff;
	reg [31:0] availFf;
	reg [4:0]  stateFf;
	reg [4:0]  nxt_state;
	reg [31:0] lbaFf;
	reg [31:0] xferFf;
	reg [3:0]  statusCodeFf;
	reg [3:0]  senseKeyFf;
	reg [2:0]  outcomeFf;
	reg [2:0]  lunFf;
	reg        busyFf;
	reg        waitFf;

	// Decoded bytes of the command block, byte 0 first
	wire [7:0] cdbByte [0:11];
	assign cdbByte[0]  = cdb0Ff[31:24];
	assign cdbByte[1]  = cdb0Ff[23:16];
	assign cdbByte[2]  = cdb0Ff[15:8];
	assign cdbByte[3]  = cdb0Ff[7:0];
	assign cdbByte[4]  = cdb1Ff[31:24];
	assign cdbByte[5]  = cdb1Ff[23:16];
	assign cdbByte[6]  = cdb1Ff[15:8];
	assign cdbByte[7]  = cdb1Ff[7:0];
	assign cdbByte[8]  = cdb2Ff[31:24];
	assign cdbByte[9]  = cdb2Ff[23:16];
	assign cdbByte[10] = cdb2Ff[15:8];
	assign cdbByte[11] = cdb2Ff[7:0];

	// ----------------------------------------
	// Field split of opcode and control byte
	// ----------------------------------------
	wire [2:0] groupCode;
	wire [4:0] cmdCode;
	wire [3:0] blockLen;
	wire       validGroup;
	wire       flagBit;
	wire       linkBit;
	wire [7:0] ctrlByte;

	// Control byte is the last byte of the block
	assign ctrlByte = (blockLen == `LEN_SIX) ? cdbByte[5] :
	                  (blockLen == `LEN_TEN) ? cdbByte[9] : cdbByte[11];

	cdb_field_split uSplit (
		.opCode     (cdbByte[0]),
		.ctrlByte   (ctrlByte),
		.groupCode  (groupCode),
		.cmdCode    (cmdCode),
		.blockLen   (blockLen),
		.validGroup (validGroup),
		.flagBit    (flagBit),
		.linkBit    (linkBit),
		.vendorBits ()
	);

	// ----------------------------------------
	// Address and length assembly
	// ----------------------------------------
	wire        isSix;
	wire [31:0] lbaNext;
	wire [31:0] lenRaw;
	wire [31:0] lenEff;
	wire [1:0]  lenKind;

	assign isSix   = (blockLen == `LEN_SIX);
	assign lenKind = ctrlFf[`CTRL_LENKIND_HI:`CTRL_LENKIND_LO];

	// Address MSB first; 21 bits in six-byte blocks
	assign lbaNext = isSix ? {11'h0, cdbByte[1][4:0], cdbByte[2], cdbByte[3]}
	               : {cdbByte[2], cdbByte[3], cdbByte[4], cdbByte[5]};

	// Length field position depends on block size, MSB first
	assign lenRaw = isSix ? {24'h0, cdbByte[4]} :
	                (blockLen == `LEN_TEN) ? {16'h0, cdbByte[7], cdbByte[8]}
	                : {cdbByte[6], cdbByte[7], cdbByte[8], cdbByte[9]};

	// One-byte transfer length zero means 256 blocks
	assign lenEff = (isSix && lenKind == `LEN_TRANSFER && lenRaw == 32'h0) ? 32'h100
	              : lenRaw;

	// ----------------------------------------
	// Data counter, limited by available data for allocation lengths
	// ----------------------------------------
	wire [31:0] limitNext;
	wire        cntDone;
	wire [31:0] cntSent;
	wire        cntLoad;
	wire        cntStep;

	// Allocation length caps what is returned; the length being decoded is
	// used, as xferFf only takes it at the same edge as the counter load
	assign limitNext = (lenKind == `LEN_ALLOC && availFf < lenEff) ? availFf : lenEff;
	// Counter loads as the sequencer enters the transfer state
	assign cntLoad   = stateFf[2] == 1'b0 && nxt_state == ST_XFER;
	// One unit per cycle while transferring with stepping on
	assign cntStep   = stateFf[2] && ctrlFf[`CTRL_STEP_BIT];

	byte_counter uCount (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.load     (cntLoad),
		.limit    (limitNext),
		.step     (cntStep),
		.done     (cntDone),
		.sent     (cntSent)
	);

	// ----------------------------------------
	// Command check
	// ----------------------------------------
	wire badCtrl;
	wire badCmd;

	// Flag without link is illegal; link or flag illegal without link support
	assign badCtrl = (flagBit && !linkBit)
	              || (!ctrlFf[`CTRL_LINKOK_BIT] && (flagBit || linkBit));
	assign badCmd  = badCtrl || !validGroup;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always @* begin
		nxt_state = stateFf;
		case (stateFf)
			ST_IDLE:   if (busyFf) nxt_state = ST_DECODE;
			ST_DECODE: nxt_state = badCmd ? ST_STATUS : ST_XFER;
			ST_XFER:   if (cntDone) nxt_state = ST_STATUS;
			ST_STATUS: nxt_state = ST_MSG;
			ST_MSG:    nxt_state = ST_IDLE;
			default:   nxt_state = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Sequencer and results
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!rst_b) begin
			stateFf       <= ST_IDLE;
			lbaFf         <= 32'h0;
			xferFf        <= 32'h0;
			statusCodeFf  <= STS_GOOD;
			senseKeyFf    <= 4'h0;
			outcomeFf     <= `OUT_NONE;
			lunFf         <= 3'h0;
			mediumWriteEn <= 1'b0;
			cmdPhase      <= 1'b1;
			dataInActive  <= 1'b0;
		end else begin
			stateFf <= nxt_state;
			case (stateFf)
				ST_DECODE: begin
					cmdPhase <= 1'b0;
					lbaFf    <= lbaNext;
					xferFf   <= lenEff;
					// Unit from block only when no identify was seen
					lunFf    <= ctrlFf[`CTRL_IDENT_BIT] ? lunFf : cdbByte[1][7:5];
					if (badCmd) begin
						statusCodeFf <= STS_CHECK;
						senseKeyFf   <= SENSE_ILLEGAL;
						outcomeFf    <= `OUT_CHECK;
					end else begin
						senseKeyFf   <= 4'h0;
						// Medium touched only by valid commands
						mediumWriteEn <= (lenKind != `LEN_ALLOC) && (lenEff != 32'h0);
						// Data-in only when something is to be returned
						dataInActive  <= (lenKind == `LEN_ALLOC) && (limitNext != 32'h0);
					end
				end
				ST_XFER: begin
					if (cntDone) begin
						mediumWriteEn <= 1'b0;
						dataInActive  <= 1'b0;
					end
				end
				ST_STATUS: begin
					mediumWriteEn <= 1'b0;
					dataInActive  <= 1'b0;
					if (outcomeFf != `OUT_CHECK) begin
						// Forced failure overrides the link outcome
						if (ctrlFf[`CTRL_FAIL_BIT]) begin
							statusCodeFf <= STS_CHECK;
							outcomeFf    <= `OUT_CHECK;
						end else if (linkBit) begin
							statusCodeFf <= STS_INTER;
							outcomeFf    <= flagBit ? `OUT_LINKED_FLAG : `OUT_LINKED;
						end else begin
							statusCodeFf <= STS_GOOD;
							outcomeFf    <= `OUT_COMPLETE;
						end
					end
				end
				ST_MSG: begin
					// Linked success or plain end both return to command phase
					cmdPhase <= 1'b1;
				end
				ST_IDLE: begin
					if (busyFf) begin
						outcomeFf    <= `OUT_NONE;
						statusCodeFf <= STS_GOOD;
					end
				end
				default: begin
					cmdPhase <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Avalon-MM register access
	// ----------------------------------------
	wire accessGo;
	wire goWrite;

	// Master must hold the request through the wait state
	// One wait cycle on every access
	assign avs_waitrequest = (avs_read || avs_write) && !waitFf;
	assign accessGo        = (avs_read || avs_write) && waitFf;
	assign goWrite         = accessGo && avs_write && avs_address == `REG_CTRL
	                       && avs_byteenable[0] && avs_writedata[`CTRL_GO_BIT];

	// Busy set by go, cleared when the message step ends
	always @(posedge core_clk) begin
		if (!rst_b) begin
			waitFf <= 1'b0;
			busyFf <= 1'b0;
		end else begin
			waitFf <= (avs_read || avs_write) && !waitFf;
			if (goWrite && stateFf == ST_IDLE)
				busyFf <= 1'b1;
			else if (stateFf == ST_MSG)
				busyFf <= 1'b0;
		end
	end

	// Register writes, byte lane 0 honoured for the control register only
	always @(posedge core_clk) begin
		if (!rst_b) begin
			ctrlFf  <= `CTRL_RESET;
			cdb0Ff  <= 32'h0;
			cdb1Ff  <= 32'h0;
			cdb2Ff  <= 32'h0;
			availFf <= 32'h0;
		end else if (accessGo && avs_write) begin
			case (avs_address)
				`REG_CTRL:  if (avs_byteenable[0]) ctrlFf <= {avs_writedata[7:1], 1'b0};
				`REG_CDB0:  cdb0Ff  <= avs_writedata;
				`REG_CDB1:  cdb1Ff  <= avs_writedata;
				`REG_CDB2:  cdb2Ff  <= avs_writedata;
				`REG_AVAIL: availFf <= avs_writedata;
				default:    ctrlFf  <= ctrlFf;
			endcase
		end
	end

	// Read data captured at the end of the wait cycle, so it stands
	// at the accepting edge and holds until the next read
	always @(posedge core_clk) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				`REG_CTRL:   avs_readdata <= {24'h0, ctrlFf};
				`REG_CDB0:   avs_readdata <= cdb0Ff;
				`REG_CDB1:   avs_readdata <= cdb1Ff;
				`REG_CDB2:   avs_readdata <= cdb2Ff;
				`REG_STATUS: avs_readdata <= {15'h0, cmdCode, groupCode, blockLen, validGroup, stateFf[4:2],
				                              busyFf};
				`REG_LBA:    avs_readdata <= lbaFf;
				`REG_XFER:   avs_readdata <= xferFf;
				`REG_AVAIL:  avs_readdata <= availFf;
				`REG_RESULT: avs_readdata <= {17'h0, lunFf, senseKeyFf, statusCodeFf, 1'b0, outcomeFf};
				`REG_SENT:   avs_readdata <= cntSent;
				default:     avs_readdata <= 32'h0;
			endcase
		end
	end
endmodule

// ---- hdl/cdb_field_split.v ----
`timescale 1ns/1ps

// Splits the operation code and control byte of a command block
module cdb_field_split (
	// Operation code and control byte
	input  wire [7:0] opCode,
	input  wire [7:0] ctrlByte,
	// Decoded fields
	output wire [2:0] groupCode,
	output wire [4:0] cmdCode,
	output reg  [3:0] blockLen,
	output wire       validGroup,
	output wire       flagBit,
	output wire       linkBit,
	output wire [1:0] vendorBits
);
	// Group in upper three bits, command in lower five
	assign groupCode  = opCode[7:5];
	assign cmdCode    = opCode[4:0];

	// Control byte layout
	assign flagBit    = ctrlByte[1];
	assign linkBit    = ctrlByte[0];
	assign vendorBits = ctrlByte[7:6];

	// Block length from group; zero for reserved and vendor groups
	always @* begin
		case (groupCode)
			`GROUP_SIX:    blockLen = `LEN_SIX;
			`GROUP_TEN_A:  blockLen = `LEN_TEN;
			`GROUP_TEN_B:  blockLen = `LEN_TEN;
			`GROUP_TWELVE: blockLen = `LEN_TWELVE;
			default:       blockLen = 4'h0;
		endcase
	end
	assign validGroup = (blockLen != 4'h0);
endmodule

// ---- verification/cdb_decoder_chk.sv ----
`timescale 1ns/1ps

// --------
// Bus and phase checks
// --------
module cdb_decoder_chk (
	// Clock and reset
	input wire        core_clk,
	input wire        rst_b,
	// Register bus
	input wire [3:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Phase outputs
	input wire        mediumWriteEn,
	input wire        cmdPhase,
	input wire        dataInActive
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// One wait state on every request
	AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("new request without wait state");
	AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state longer than one cycle");
	AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait state without request");

	// Read data only changes at the end of a read's wait state
	AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && avs_address > 4'h9 |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without read");

	// Data-in and data-out never overlap, and both leave the command phase
	AST_ONE_DIRECTION: assert property (!(mediumWriteEn && dataInActive))
		else $error("data-in and medium write together");
	AST_NO_CMD_IN_DATA: assert property (mediumWriteEn || dataInActive |-> !cmdPhase)
		else $error("command phase during data transfer");
	AST_BACK_TO_CMD: assert property ($fell(mediumWriteEn || dataInActive) |-> ##[0:8] cmdPhase)
		else $error("no return to command phase");
endmodule

bind cdb_field_decoder cdb_decoder_chk u_chk (
	.core_clk       (core_clk),
	.rst_b          (rst_b),
	.avs_address    (avs_address),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_writedata  (avs_writedata),
	.avs_byteenable (avs_byteenable),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.mediumWriteEn  (mediumWriteEn),
	.cmdPhase       (cmdPhase),
	.dataInActive   (dataInActive)
);

// ---- verification/initiator_model.sv ----
`timescale 1ns/1ps

// --------
// Initiator side bus master
// --------
module initiator_model (
	// Clock
	input  wire         core_clk,
	// Bus request
	output logic [3:0]  avs_address,
	output logic        avs_read,
	output logic        avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0]  avs_byteenable,
	// Bus answer
	input  wire  [31:0] avs_readdata,
	input  wire         avs_waitrequest
);
	// Idle bus at time zero
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end

	// Holds the write until wait state ends, then scrambles released lines
	task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask

	// Read data stand at the edge where the wait state ends and are taken there
	task automatic busRead(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_address <= ~a;
	endtask

	// Command block goes out opcode first, most significant byte first
	task automatic sendCdb(input logic [95:0] blk);
		busWrite(4'h1, blk[95:64]);
		busWrite(4'h2, blk[63:32]);
		busWrite(4'h3, blk[31:0]);
	endtask
endmodule

// ---- verification/test_cdb_field_decoder.sv ----
`timescale 1ns/1ps
`include "cdb_decoder_consts.vh"

module test_cdb_field_decoder;
	// --------
	// Signals
	// --------
	logic        core_clk;
	logic        rst_b;
	wire  [3:0]  avs_address;
	wire         avs_read;
	wire         avs_write;
	wire  [31:0] avs_writedata;
	wire  [3:0]  avs_byteenable;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         mediumWriteEn;
	wire         cmdPhase;
	wire         dataInActive;
	int          bad_count = 0;
	int          checks_done = 0;
	logic        medSeen = 1'b0;
	logic        dinSeen = 1'b0;
	logic [31:0] st, res, lba, xfer, sent, d;
	logic [19:0] ctlTab [8] = '{20'h04001, 20'h04024, 20'h04012, 20'h04033, 20'h00014, 20'h00024, 20'h04c01,
		20'h0c014};
	logic [3:0]  o;

	cdb_field_decoder DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mediumWriteEn(mediumWriteEn),
		.cmdPhase(cmdPhase), .dataInActive(dataInActive));
	initiator_model host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Remembers any data movement during a command
	always @(posedge core_clk) begin
		if (mediumWriteEn === 1'b1) medSeen <= 1'b1;
		if (dataInActive === 1'b1) dinSeen <= 1'b1;
	end

	// --------
	// Tasks
	// --------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Loads a block, starts it with stepping on, waits for idle, reads results
	task automatic run(input logic [95:0] blk, input logic [31:0] avail, input logic [7:0] ctl);
		int n;
		host.sendCdb(blk);
		host.busWrite(`REG_AVAIL, avail);
		medSeen = 1'b0;
		dinSeen = 1'b0;
		host.busWrite(`REG_CTRL, {24'h0, ctl | 8'h41});
		n = 0;
		st = 32'h1;
		while (st[0] !== 1'b0 && n < 400) begin
			host.busRead(`REG_STATUS, st);
			n++;
		end
		chk("busy", 32'h0, 32'(st[0]));
		host.busRead(`REG_RESULT, res);
		host.busRead(`REG_LBA, lba);
		host.busRead(`REG_XFER, xfer);
		host.busRead(`REG_SENT, sent);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (80000) @(posedge core_clk);
		bad_count++;
		finish_test();
	end

	// --------
	// Tests
	// --------
	initial begin
		rst_b = 1'b0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		// Every group: split, length, and rejection without medium change
		for (int g = 0; g < 8; g++) begin
			run({3'(g), 5'h0a, 88'h0}, 32'h0, 8'h00);
			chk("group", 32'(g), 32'(st[11:9]));
			chk("cmd", 32'h0a, 32'(st[16:12]));
			chk("valid", 32'(g < 3 || g == 5), 32'(st[4]));
			if (g < 3 || g == 5) chk("len", g == 0 ? 6 : (g == 5 ? 12 : 10), 32'(st[8:5]));
			chk("out", (g < 3 || g == 5) ? `OUT_COMPLETE : `OUT_CHECK, 32'(res[2:0]));
			chk("medium", 32'(g == 0), 32'(medSeen));
			if (g == 0) chk("xfer256", 32'd256, xfer);
		end
		$display("test groups done");
		// Six-byte address and unit number, then identify keeps the unit
		run({8'h08, 8'h5f, 8'hab, 8'hcd, 8'h05, 8'h00, 48'h0}, 32'h0, 8'h00);
		chk("lba21", 32'h001fabcd, lba);
		chk("xfer5", 32'h5, xfer);
		chk("sent5", 32'h5, sent);
		chk("lun", 32'h2, 32'(res[14:12]));
		run({8'h08, 8'ha0, 8'h00, 8'h07, 8'h01, 8'h00, 48'h0}, 32'h0, 8'h02);
		chk("lunkept", 32'h2, 32'(res[14:12]));
		chk("lbazero", 32'h7, lba);
		$display("test six-byte done");
		// Ten and twelve byte fields, unit zero as recommended
		run({8'h28, 8'h00, 32'h12345678, 8'h00, 16'h0003, 8'h00, 16'h0}, 32'h0, 8'h00);
		chk("lba32", 32'h12345678, lba);
		chk("xfer3", 32'h3, xfer);
		run({8'h28, 8'h00, 32'h12345678, 8'h00, 16'h0000, 8'h00, 16'h0}, 32'h0, 8'h00);
		chk("xfer0", 32'h0, xfer);
		chk("nomove", 32'h0, 32'(medSeen));
		run({8'ha8, 8'h00, 32'h87654321, 32'h00000102, 8'h00, 8'h00}, 32'h0, 8'h00);
		chk("lba12", 32'h87654321, lba);
		chk("xfer12", 32'h102, xfer);
		// Parameter list length zero and nonzero
		run({8'h28, 8'h00, 32'h0, 8'h00, 16'h0000, 8'h00, 16'h0}, 32'h0, 8'h10);
		chk("par0", {`OUT_COMPLETE}, 32'(res[2:0]));
		chk("par0st", 32'h0, 32'(res[7:4]));
		run({8'h28, 8'h00, 32'h0, 8'h00, 16'h0004, 8'h00, 16'h0}, 32'h0, 8'h10);
		chk("par4", 32'h1, 32'(medSeen));
		// Allocation length against available data
		for (int i = 0; i < 3; i++) begin
			run({8'h28, 8'h00, 32'h0, 8'h00, 16'(i == 0 ? 10 : (i == 1 ? 3 : 0)), 8'h00, 16'h0},
				i == 1 ? 32'h9 : 32'h4, 8'h20);
			chk("sent", i == 0 ? 32'h4 : (i == 1 ? 32'h3 : 32'h0), sent);
			chk("datain", 32'(i < 2), 32'(dinSeen));
			chk("aout", {`OUT_COMPLETE}, 32'(res[2:0]));
		end
		$display("test lengths done");
		// Control byte: flag and link with and without link support
		for (int i = 0; i < 8; i++) begin
			run({8'h08, 32'h0, ctlTab[i][11:4], 48'h0}, 32'h0, ctlTab[i][19:12]);
			o = ctlTab[i][3:0];
			chk("ctlout", 32'(o), 32'(res[2:0]));
			chk("ctlst", o == 4 ? 32'h1 : (o > 1 ? 32'h4 : 32'h0), 32'(res[7:4]));
			if (o == 4) chk("sense", ctlTab[i][15] ? 32'h0 : 32'h5, 32'(res[11:8]));
			chk("ctlmed", 32'(o != 4 || ctlTab[i][15]), 32'(medSeen));
			chk("cmdphase", 32'h1, 32'(cmdPhase));
		end
		host.busRead(4'hf, d);
		chk("unmapped", 32'h0, d);
		$display("test control done");
		finish_test();
	end
endmodule
